// ### pkg/ppo_pkg.sv
/*
 * Constants, register map and carrier types of the pulse pattern output.
 * Assumes an 8-bit register port with 16-bit byte addresses and a 40 MHz clock.
 */
package ppo_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_PORT1_DIR = 16'hfeb0;
   localparam logic [15:0] ADDR_PORT2_DIR = 16'hfeb1;
   localparam logic [15:0] ADDR_HALT_HI = 16'hff3c;
   localparam logic [15:0] ADDR_HALT_LO = 16'hff3d;
   localparam logic [15:0] ADDR_TRIG_SEL = 16'hff46;
   localparam logic [15:0] ADDR_MODE = 16'hff47;
   localparam logic [15:0] ADDR_EN_HI = 16'hff48;
   localparam logic [15:0] ADDR_EN_LO = 16'hff49;
   localparam logic [15:0] ADDR_OUT_HI = 16'hff4a;
   localparam logic [15:0] ADDR_OUT_LO = 16'hff4b;
   localparam logic [15:0] ADDR_STG_HI = 16'hff4c;
   localparam logic [15:0] ADDR_STG_LO = 16'hff4d;
   localparam logic [15:0] ADDR_STG_HI_ALT = 16'hff4e;
   localparam logic [15:0] ADDR_STG_LO_ALT = 16'hff4f;
   localparam logic [15:0] ADDR_PAT_LO = 16'hff50;
   localparam logic [15:0] ADDR_PAT_HI = 16'hff51;
   localparam logic [15:0] ADDR_PAT_STAT = 16'hff52;

   // ----------------------------------------------------------------
   // Reset values and fields
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_HALT = 16'h3fff;
   localparam logic [7:0] RST_TRIG_SEL = 8'hff;
   localparam logic [7:0] RST_MODE = 8'hf0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RESERVED_BYTE = 8'hff;
   localparam logic [3:0] RESERVED_NIB = 4'hf;
   localparam int HALT_BIT = 11;
   localparam int MODE_DIRECT_POS = 4;
   localparam int MODE_NONOVL_POS = 0;
   localparam int GROUPS = 4;
   localparam int GROUP_W = 4;
   localparam int PINS = 16;
   localparam int CHANNELS = 4;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_WIDTH = 16;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int GUARD_NS = 100;
   localparam int GUARD_CYC_RAW = (GUARD_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] GUARD_CYC = (GUARD_CYC_RAW < 1) ? 4'h1 : 4'(GUARD_CYC_RAW);

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } reg_req_t;

   typedef struct packed {
      logic [15:0] value;
      logic [15:0] drive_n;
   } pin_bank_t;
endpackage

// ### logic/pulse_pattern_output.sv
/*
 * Pulse pattern output: sixteen pins in four groups, timer-triggered
 * staged-to-output transfer, register port, and a pattern word FIFO.
 * Assumes compare-match strobes are one-cycle pulses on ref_clk_i and
 * the standby request arrives asynchronously from a pin.
 */
`timescale 1ns/100ps

module pattern_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic clear_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH+1)-1:0] level_o
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [$clog2(DEPTH+1)-1:0] count;
   logic push;
   logic pop;

   // Full and empty come straight from the stored count
   assign in_ready_o = (count != ($clog2(DEPTH+1))'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign level_o = count;
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // Storage has no reset; only the pointers and count carry state
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and count
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (clear_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
      end
   end
endmodule // pattern_fifo

module pulse_pattern_output (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic hw_standby_i,
   input wire ppo_pkg::reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [ppo_pkg::CHANNELS-1:0] compare_match_i,
   output logic [ppo_pkg::CHANNELS-1:0] xfer_req_o,
   output ppo_pkg::pin_bank_t pins_o,
   output logic pattern_ready_o
);
   import ppo_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic stby_meta;
   logic stby;
   logic [15:0] halt_ctl;
   logic [15:0] port_dir;
   logic [7:0] trig_sel;
   logic [7:0] mode;
   logic [15:0] next_en;
   logic [15:0] out_val;
   logic [15:0] staged;
   logic [7:0] pat_lo;
   logic [GROUPS-1:0] trig;
   logic [GROUPS-1:0] guard_busy;
   logic [3:0] guard_cnt [GROUPS];
   logic [GROUP_W-1:0] pending [GROUPS];
   logic halted;
   logic same_hi;
   logic same_lo;
   logic wr;
   logic rd;
   logic [15:0] next_out;
   logic [15:0] next_staged;
   logic [7:0] next_rdata;
   logic stg_write;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [15:0] fifo_head;
   logic [2:0] fifo_level;
   logic fifo_push;

   // Standby pin is asynchronous: two flops before use
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stby_meta <= 1'b0;
         stby <= 1'b0;
      end else begin
         stby_meta <= hw_standby_i;
         stby <= stby_meta;
      end
   end

   assign halted = halt_ctl[HALT_BIT];
   assign wr = reg_req_i.we;
   assign rd = reg_req_i.re;
   assign same_hi = (trig_sel[7:6] == trig_sel[5:4]);
   assign same_lo = (trig_sel[3:2] == trig_sel[1:0]);

   // ----------------------------------------------------------------
   // Trigger selection
   // ----------------------------------------------------------------
   // A halted block ignores the timer entirely
   always_comb begin
      for (int g = 0; g < GROUPS; g++) begin
         trig[g] = compare_match_i[trig_sel[2*g +: 2]] & ~halted;
      end
   end

   // Channels picked by any group also request the transfer engines
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         xfer_req_o <= '0;
      end else begin
         for (int c = 0; c < CHANNELS; c++) begin
            xfer_req_o[c] <= 1'b0;
            for (int g = 0; g < GROUPS; g++) begin
               if (trig_sel[2*g +: 2] == 2'(c) && !halted && !stby) begin
                  xfer_req_o[c] <= compare_match_i[c];
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Halt control and port direction stay writable while the rest is locked out
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         halt_ctl <= RST_HALT;
      end else if (wr && reg_req_i.addr == ADDR_HALT_HI) begin
         halt_ctl[15:8] <= reg_req_i.wdata;
      end else if (wr && reg_req_i.addr == ADDR_HALT_LO) begin
         halt_ctl[7:0] <= reg_req_i.wdata;
      end
   end

   // Port direction belongs to the port and is not behind module halt
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         port_dir <= '0;
      end else if (stby) begin
         port_dir <= '0;
      end else if (wr && reg_req_i.addr == ADDR_PORT1_DIR) begin
         port_dir[7:0] <= reg_req_i.wdata;
      end else if (wr && reg_req_i.addr == ADDR_PORT2_DIR) begin
         port_dir[15:8] <= reg_req_i.wdata;
      end
   end

   // Trigger select, mode and enables; standby clears like reset
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         trig_sel <= RST_TRIG_SEL;
         mode <= RST_MODE;
         next_en <= '0;
      end else if (stby) begin
         trig_sel <= RST_TRIG_SEL;
         mode <= RST_MODE;
         next_en <= '0;
      end else if (wr && !halted) begin
         unique case (reg_req_i.addr)
            ADDR_TRIG_SEL: trig_sel <= reg_req_i.wdata;
            ADDR_MODE: mode <= reg_req_i.wdata;
            ADDR_EN_HI: next_en[15:8] <= reg_req_i.wdata;
            ADDR_EN_LO: next_en[7:0] <= reg_req_i.wdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Staged value with address aliasing
   // ----------------------------------------------------------------
   always_comb begin
      next_staged = staged;
      stg_write = 1'b0;
      if (wr && !halted) begin
         unique case (reg_req_i.addr)
            ADDR_STG_HI: begin
               stg_write = 1'b1;
               next_staged[15:12] = reg_req_i.wdata[7:4];
               if (same_hi) begin
                  next_staged[11:8] = reg_req_i.wdata[3:0];
               end
            end
            ADDR_STG_HI_ALT: begin
               stg_write = !same_hi;
               if (!same_hi) begin
                  next_staged[11:8] = reg_req_i.wdata[3:0];
               end
            end
            ADDR_STG_LO: begin
               stg_write = 1'b1;
               next_staged[7:4] = reg_req_i.wdata[7:4];
               if (same_lo) begin
                  next_staged[3:0] = reg_req_i.wdata[3:0];
               end
            end
            ADDR_STG_LO_ALT: begin
               stg_write = !same_lo;
               if (!same_lo) begin
                  next_staged[3:0] = reg_req_i.wdata[3:0];
               end
            end
            default: ;
         endcase
      end
   end

   // A queued pattern reloads the stage after a trigger; software wins
   assign fifo_pop = (|trig) & ~stg_write & ~stby;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         staged <= '0;
      end else if (stby) begin
         staged <= '0;
      end else if (stg_write) begin
         staged <= next_staged;
      end else if (fifo_pop && fifo_out_valid) begin
         staged <= fifo_head;
      end
   end

   // ----------------------------------------------------------------
   // Pattern FIFO: low byte is held, high byte write pushes the word
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pat_lo <= '0;
      end else if (wr && !halted && reg_req_i.addr == ADDR_PAT_LO) begin
         pat_lo <= reg_req_i.wdata;
      end
   end

   // A push into a full FIFO is dropped; software polls the ready bit
   assign fifo_push = wr && !halted && reg_req_i.addr == ADDR_PAT_HI;

   pattern_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .clear_i(stby),
      .in_valid_i(fifo_push),
      .in_ready_o(fifo_in_ready),
      .in_data_i({reg_req_i.wdata, pat_lo}),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_head),
      .level_o(fifo_level)
   );

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pattern_ready_o <= 1'b0;
      end else begin
         pattern_ready_o <= fifo_in_ready & ~halted;
      end
   end

   // ----------------------------------------------------------------
   // Output value: transfer, non-overlap guard, software writes
   // ----------------------------------------------------------------
   // Falling bits move at once, rising bits wait out the guard
   always_comb begin
      next_out = out_val;
      if (wr && !halted && reg_req_i.addr == ADDR_OUT_HI) begin
         next_out[15:8] = (out_val[15:8] & next_en[15:8])
                        | (reg_req_i.wdata & ~next_en[15:8]);
      end
      if (wr && !halted && reg_req_i.addr == ADDR_OUT_LO) begin
         next_out[7:0] = (out_val[7:0] & next_en[7:0])
                       | (reg_req_i.wdata & ~next_en[7:0]);
      end
      for (int g = 0; g < GROUPS; g++) begin
         if (guard_busy[g] && guard_cnt[g] == 4'h1) begin
            next_out[GROUP_W*g +: GROUP_W] = pending[g];
         end
         if (trig[g]) begin
            if (mode[MODE_NONOVL_POS + g]) begin
               next_out[GROUP_W*g +: GROUP_W] = out_val[GROUP_W*g +: GROUP_W]
                  & (staged[GROUP_W*g +: GROUP_W] | ~next_en[GROUP_W*g +: GROUP_W]);
            end else begin
               next_out[GROUP_W*g +: GROUP_W] = (staged[GROUP_W*g +: GROUP_W] & next_en[GROUP_W*g +: GROUP_W])
                  | (out_val[GROUP_W*g +: GROUP_W] & ~next_en[GROUP_W*g +: GROUP_W]);
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_val <= '0;
      end else if (stby) begin
         out_val <= '0;
      end else begin
         out_val <= next_out;
      end
   end

   // Per-group guard timers; a new trigger restarts the margin
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         guard_busy <= '0;
         for (int g = 0; g < GROUPS; g++) begin
            guard_cnt[g] <= '0;
            pending[g] <= '0;
         end
      end else if (stby) begin
         guard_busy <= '0;
      end else begin
         for (int g = 0; g < GROUPS; g++) begin
            if (trig[g] && mode[MODE_NONOVL_POS + g]) begin
               guard_busy[g] <= 1'b1;
               guard_cnt[g] <= GUARD_CYC;
               pending[g] <= (staged[GROUP_W*g +: GROUP_W] & next_en[GROUP_W*g +: GROUP_W])
                  | (out_val[GROUP_W*g +: GROUP_W] & ~next_en[GROUP_W*g +: GROUP_W]);
            end else if (guard_busy[g]) begin
               guard_cnt[g] <= guard_cnt[g] - 4'h1;
               guard_busy[g] <= (guard_cnt[g] != 4'h1);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   // A clear direct bit inverts the whole group on the pins
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pins_o.value <= '0;
         pins_o.drive_n <= '1;
      end else begin
         for (int g = 0; g < GROUPS; g++) begin
            pins_o.value[GROUP_W*g +: GROUP_W] <= out_val[GROUP_W*g +: GROUP_W]
               ^ {GROUP_W{~mode[MODE_DIRECT_POS + g]}};
         end
         pins_o.drive_n <= ~port_dir;
      end
   end

   // ----------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = RST_BYTE;
      unique case (reg_req_i.addr)
         ADDR_HALT_HI: next_rdata = halt_ctl[15:8];
         ADDR_HALT_LO: next_rdata = halt_ctl[7:0];
         default: ;
      endcase
      if (!halted) begin
         unique case (reg_req_i.addr)
            ADDR_TRIG_SEL: next_rdata = trig_sel;
            ADDR_MODE: next_rdata = mode;
            ADDR_EN_HI: next_rdata = next_en[15:8];
            ADDR_EN_LO: next_rdata = next_en[7:0];
            ADDR_OUT_HI: next_rdata = out_val[15:8];
            ADDR_OUT_LO: next_rdata = out_val[7:0];
            ADDR_STG_HI: next_rdata = same_hi ? staged[15:8] : {staged[15:12], RESERVED_NIB};
            ADDR_STG_HI_ALT: next_rdata = same_hi ? RESERVED_BYTE : {RESERVED_NIB, staged[11:8]};
            ADDR_STG_LO: next_rdata = same_lo ? staged[7:0] : {staged[7:4], RESERVED_NIB};
            ADDR_STG_LO_ALT: next_rdata = same_lo ? RESERVED_BYTE : {RESERVED_NIB, staged[3:0]};
            ADDR_PAT_LO: next_rdata = pat_lo;
            ADDR_PAT_STAT: next_rdata = {4'h0, fifo_in_ready, fifo_level};
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= '0;
      end else if (rd) begin
         reg_rdata_o <= next_rdata;
      end else begin
         reg_rdata_o <= '0;
      end
   end
endmodule // pulse_pattern_output

// ### verif/ppo_sva.sv
/*
 * Port checker for the pulse pattern output.
 * Assumes it is bound onto the top module and sees one clock domain.
 */
`timescale 1ns/100ps
module ppo_sva (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic hw_standby_i,
   input wire ppo_pkg::reg_req_t reg_req_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [ppo_pkg::CHANNELS-1:0] compare_match_i,
   input wire logic [ppo_pkg::CHANNELS-1:0] xfer_req_o,
   input wire ppo_pkg::pin_bank_t pins_o,
   input wire logic pattern_ready_o
);
   import ppo_pkg::*;
   // ------------------------------------------------
   // Quiet time since the last cause of pin motion
   // ------------------------------------------------
   logic [3:0] quiet;
   // Eight idle cycles cover the guard delay plus the pin register
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i)
         quiet <= 4'h0;
      else if (reg_req_i.we || (|compare_match_i) || hw_standby_i)
         quiet <= 4'h0;
      else if (quiet != 4'hf)
         quiet <= quiet + 4'h1;
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_rdata_idle: assert property (!$past(reg_req_i.re) |-> reg_rdata_o == 8'h00)
      else $error("read data outside its slot");
   a_xfer_cause: assert property ((xfer_req_o & ~$past(compare_match_i)) == 4'h0)
      else $error("transfer request without strobe");
   a_xfer_quiet: assert property (compare_match_i == 4'h0 |=> xfer_req_o == 4'h0)
      else $error("transfer request after idle cycle");
   a_drive_reset: assert property ($rose(resetn_i) |-> pins_o.drive_n == 16'hffff && pins_o.value == 16'h0000)
      else $error("pins not idle after reset");
   a_pins_hold: assert property (quiet >= 4'h8 |-> $stable(pins_o.value))
      else $error("pin value moved without cause");
   a_drive_hold: assert property (quiet >= 4'h8 |-> $stable(pins_o.drive_n))
      else $error("drive enable moved without cause");
   a_ready_hold: assert property (quiet >= 4'h8 |-> $stable(pattern_ready_o))
      else $error("ready moved without cause");
   a_standby_clear: assert property (hw_standby_i [*6] |-> pins_o.value == 16'h0000 && pins_o.drive_n == 16'hffff)
      else $error("standby did not clear pins");
endmodule // ppo_sva

// ### verif/timer_strobe_model.sv
/*
 * Behavioural timer channel unit: one-cycle compare-match strobes.
 * Assumes the bench calls strobe and shares the block's clock.
 */
`timescale 1ns/100ps
module timer_strobe_model (
   input wire logic ref_clk_i,
   output logic [3:0] compare_match_o
);
   initial compare_match_o = 4'h0;
   // A long gap stands in for a slow timer period
   task automatic strobe(input int ch, input int gap);
      repeat (gap) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      compare_match_o <= 4'(1 << ch);
      @(posedge ref_clk_i);
      compare_match_o <= 4'h0;
   endtask
endmodule // timer_strobe_model

// ### verif/pulse_pattern_output_tb.sv
/*
 * Self-checking bench for the pulse pattern output.
 * Assumes the timer model drives the strobes and the checker is bound.
 */
`timescale 1ns/100ps
module pulse_pattern_output_tb;
   import ppo_pkg::*;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic hw_standby_i = 1'b0;
   reg_req_t req = '0;
   logic [7:0] rdata;
   logic [3:0] cm;
   logic [3:0] xfer;
   pin_bank_t pins;
   logic ready;
   int num_errors = 0;
   int total_checks = 0;
   logic [15:0] out_exp;
   logic [7:0] hv [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};

   always #12.5 ref_clk_i = ~ref_clk_i;

   pulse_pattern_output DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hw_standby_i(hw_standby_i),
      .reg_req_i(req), .reg_rdata_o(rdata), .compare_match_i(cm), .xfer_req_o(xfer), .pins_o(pins),
      .pattern_ready_o(ready));
   timer_strobe_model tmr (.ref_clk_i(ref_clk_i), .compare_match_o(cm));

   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge ref_clk_i);
      req.we <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      @(posedge ref_clk_i);
      req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge ref_clk_i);
      req.re <= 1'b0;
      #1 check({8'h00, rdata}, {8'h00, e});
   endtask
   task automatic fire(input int ch, input int gap, input logic [3:0] xe);
      tmr.strobe(ch, gap);
      #1 check({12'h000, xfer}, {12'h000, xe});
      repeat (2) @(posedge ref_clk_i);
      #1 check(pins.value, out_exp);
   endtask
   task automatic do_reset();
      resetn_i <= 1'b0;
      repeat (16) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      out_exp = 16'h0000;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic test_halt();
      rdc(ADDR_TRIG_SEL, 8'h00);
      rdc(ADDR_HALT_HI, 8'h3f);
      wr(ADDR_HALT_HI, 8'h00);
      rdc(ADDR_TRIG_SEL, RST_TRIG_SEL);
      rdc(ADDR_MODE, RST_MODE);
      rdc(ADDR_EN_HI, 8'h00);
      rdc(ADDR_PORT1_DIR, 8'h00);
      rdc(16'hff60, 8'h00);
      $display("test_halt done");
   endtask
   // Wrong channel first, then the selected one, for every code
   task automatic test_trigger();
      wr(ADDR_PORT1_DIR, 8'hff);
      wr(ADDR_PORT2_DIR, 8'hff);
      wr(ADDR_EN_HI, 8'hff);
      wr(ADDR_EN_LO, 8'h0f);
      #1 check(pins.drive_n, 16'h0000);
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_TRIG_SEL, {4{2'(c)}});
         wr(ADDR_STG_HI, hv[c]);
         wr(ADDR_STG_LO, ~hv[c]);
         fire((c + 1) % 4, 0, 4'h0);
         out_exp = {hv[c], out_exp[7:4], ~hv[c][3:0]};
         fire(c, c, 4'(1 << c));
      end
      rdc(ADDR_OUT_HI, hv[3]);
      $display("test_trigger done");
   endtask
   task automatic test_protect();
      wr(ADDR_OUT_LO, 8'hff);
      rdc(ADDR_OUT_LO, {4'hf, out_exp[3:0]});
      wr(ADDR_OUT_HI, 8'h00);
      rdc(ADDR_OUT_HI, out_exp[15:8]);
      out_exp[7:4] = 4'hf;
      wr(ADDR_MODE, 8'he0);
      repeat (2) @(posedge ref_clk_i);
      #1 check(pins.value, out_exp ^ 16'h000f);
      wr(ADDR_MODE, RST_MODE);
      $display("test_protect done");
   endtask
   // Split triggers, then shared, on the same staged contents
   task automatic test_alias();
      wr(ADDR_TRIG_SEL, 8'he4);
      wr(ADDR_STG_HI, 8'hab);
      wr(ADDR_STG_HI_ALT, 8'hcd);
      wr(ADDR_STG_LO, 8'h12);
      wr(ADDR_STG_LO_ALT, 8'h34);
      rdc(ADDR_STG_HI, 8'haf);
      rdc(ADDR_STG_HI_ALT, 8'hfd);
      rdc(ADDR_STG_LO, 8'h1f);
      rdc(ADDR_STG_LO_ALT, 8'hf4);
      wr(ADDR_TRIG_SEL, 8'hff);
      rdc(ADDR_STG_HI, 8'had);
      rdc(ADDR_STG_LO, 8'h14);
      rdc(ADDR_STG_LO_ALT, 8'hff);
      $display("test_alias done");
   endtask
   task automatic test_standby();
      @(posedge ref_clk_i);
      hw_standby_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      hw_standby_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      out_exp = 16'h0000;
      rdc(ADDR_EN_HI, 8'h00);
      rdc(ADDR_EN_LO, 8'h00);
      rdc(ADDR_TRIG_SEL, RST_TRIG_SEL);
      rdc(ADDR_HALT_HI, 8'h00);
      check(pins.drive_n, 16'hffff);
      $display("test_standby done");
   endtask
   // Fill past full, then drain with a slow timer
   task automatic test_fifo();
      wr(ADDR_EN_HI, 8'hff);
      wr(ADDR_EN_LO, 8'hff);
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_PAT_LO, 8'(i));
         wr(ADDR_PAT_HI, 8'(8'h80 + 8'h10 * i));
      end
      repeat (2) @(posedge ref_clk_i);
      #1 check({15'h0000, ready}, 16'h0000);
      rdc(ADDR_PAT_STAT, 8'h04);
      for (int k = 0; k < 6; k++) begin
         fire(3, 5, 4'h8);
         out_exp = {8'(8'h80 + 8'h10 * (k < 4 ? k : 3)), 8'(k < 4 ? k : 3)};
      end
      rdc(ADDR_PAT_STAT, 8'h08);
      #1 check({15'h0000, ready}, 16'h0001);
      // Group 0 non-overlap: falling bits first, rising bits after the guard
      wr(ADDR_MODE, 8'hf1);
      wr(ADDR_STG_LO, 8'h0c);
      out_exp[7:0] = 8'h00;
      fire(3, 0, 4'h8);
      repeat (3) @(posedge ref_clk_i);
      #1 check(pins.value, 16'hb00c);
      $display("test_fifo done");
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      num_errors++;
      end_of_test();
   end
   initial begin
      do_reset();
      test_halt();
      test_trigger();
      test_protect();
      test_alias();
      test_standby();
      do_reset();
      test_halt();
      test_fifo();
      end_of_test();
   end
endmodule // pulse_pattern_output_tb

bind pulse_pattern_output ppo_sva chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hw_standby_i(hw_standby_i),
   .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .compare_match_i(compare_match_i),
   .xfer_req_o(xfer_req_o), .pins_o(pins_o), .pattern_ready_o(pattern_ready_o));
